// file: verilog/lsa_pkg.sv
// Package of opcodes, field positions and reset values for the logic and shift ALU slice
package lsa_pkg;
    // Opcode field values, instruction bits 15..9
    localparam logic [6:0] OP_OR_BYTE     = 7'h64;
    localparam logic [6:0] OP_OR_WORD     = 7'h65;
    localparam logic [6:0] OP_XOR_BYTE    = 7'h66;
    localparam logic [6:0] OP_XOR_WORD    = 7'h67;
    localparam logic [6:0] OP_INV_BYTE    = 7'h4e;
    localparam logic [6:0] OP_INV_WORD    = 7'h4f;
    localparam logic [6:0] OP_NEG_BYTE    = 7'h4c;
    localparam logic [6:0] OP_NEG_WORD    = 7'h4d;
    localparam logic [6:0] OP_SHL_BYTE    = 7'h46;
    localparam logic [6:0] OP_SHLC_BYTE   = 7'h44;
    localparam logic [6:0] OP_SHL_WORD    = 7'h47;
    localparam logic [6:0] OP_SHLC_WORD   = 7'h45;
    localparam logic [6:0] OP_SHR_BYTE    = 7'h6e;
    localparam logic [6:0] OP_SHRC_BYTE   = 7'h6c;
    // Instruction field positions
    localparam int OPC_HI   = 15;
    localparam int OPC_LO   = 9;
    localparam int CCU_BIT  = 8;
    localparam int SRC_HI   = 7;
    localparam int SRC_LO   = 4;
    localparam int DST_HI   = 3;
    localparam int DST_LO   = 0;
    // Register file size
    localparam int NREG     = 16;
    // Reset values
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic       FLAG_RST = 1'b0;
endpackage

// file: verilog/lsa_alu.sv
// Logic and shift ALU slice with register file, status bits and condition codes
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// - Or-byte ORs source byte into destination byte; bit 8 selects flag form.
// - Or-word ORs source pair into destination pair; source unchanged.
// - Xor-byte exclusive-ORs source byte into destination byte.
// - Xor-word exclusive-ORs source pair into destination pair.
// - Negative and zero status follow the byte or word result.
// - Or/xor keep half and byte carry; flag form clears overflow, keeps carry.
// - Invert-byte writes inverted source; flag form keeps overflow, clears carry.
// - Invert-word inverts pair, or sign-extended odd source byte.
// - Negate-byte writes negated source; half carry from bit 3, byte carry out.
// - Negate-byte flag form sets N, Z, overflow and carry from carry out.
// - Negate-word negates pair or extended byte; byte carry out; flag clears V.
// - Shift-left-byte shifts source left, zero inserted, one microcycle.
// - Left byte shift loads byte carry with out bit, half carry from bit 3.
// - Shift family includes with-carry variants shifting in the carry code.
module lsa_alu (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        exec_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        rf_we_i,
    input  wire logic [3:0]  rf_waddr_i,
    input  wire logic [7:0]  rf_wdata_i,
    input  wire logic [3:0]  rf_raddr_i,
    output logic      [7:0]  rf_rdata_o,
    output logic             negative_status_o,
    output logic             zero_status_o,
    output logic             half_carry_status_o,
    output logic             byte_carry_status_o,
    output logic             cc_n_o,
    output logic             cc_z_o,
    output logic             cc_v_o,
    output logic             cc_c_o,
    output logic             illegal_o
);
    logic [7:0]  regs      [lsa_pkg::NREG];
    logic [7:0]  next_regs [lsa_pkg::NREG];
    logic [7:0]  rf_rdata;
    logic [7:0]  next_rf_rdata;
    logic        negative_status;
    logic        zero_status;
    logic        half_carry_status;
    logic        byte_carry_status;
    logic        next_negative_status;
    logic        next_zero_status;
    logic        next_half_carry_status;
    logic        next_byte_carry_status;
    logic        cc_n;
    logic        cc_z;
    logic        cc_v;
    logic        cc_c;
    logic        illegal;
    logic        next_cc_n;
    logic        next_cc_z;
    logic        next_cc_v;
    logic        next_cc_c;
    logic        next_illegal;

    logic [6:0]  opc;
    logic        ccu;
    logic [3:0]  src_sel;
    logic [3:0]  dst_sel;
    logic [3:0]  src_hi_sel;
    logic [3:0]  dst_hi_sel;
    logic [15:0] src_w;
    logic [15:0] dst_w;
    logic [15:0] res;
    logic        is_word;
    logic        wr_en;
    logic        h_new;
    logic        c_new;
    logic        v_new;
    logic        upd_h;
    logic        upd_c8;
    logic        cc_v_mode;
    logic        cc_c_mode;
    logic        keep_v;
    logic        do_wr;
    logic [4:0]  lo_sum;
    logic [8:0]  b_sum;
    logic [16:0] w_sum;

    assign opc        = instr_i[lsa_pkg::OPC_HI:lsa_pkg::OPC_LO];
    assign ccu        = instr_i[lsa_pkg::CCU_BIT];
    assign src_sel    = instr_i[lsa_pkg::SRC_HI:lsa_pkg::SRC_LO];
    assign dst_sel    = instr_i[lsa_pkg::DST_HI:lsa_pkg::DST_LO];
    assign src_hi_sel = src_sel + 4'h1;
    assign dst_hi_sel = dst_sel + 4'h1;
    assign do_wr      = exec_i & wr_en;

    // Odd source on a word op: single byte sign-extended through the upper eight bits
    always_comb begin
        if (src_sel[0]) begin
            src_w = {{8{regs[src_sel][7]}}, regs[src_sel]};
        end else begin
            src_w = {regs[src_hi_sel], regs[src_sel]};
        end
        dst_w = {regs[dst_hi_sel], regs[dst_sel]};
    end

    // Result and carry generation; overflow code is computed under cc_v_mode, held under keep_v, else cleared
    always_comb begin
        res       = 16'h0000;
        is_word   = 1'b0;
        wr_en     = 1'b1;
        h_new     = 1'b0;
        c_new     = 1'b0;
        v_new     = 1'b0;
        upd_h     = 1'b0;
        upd_c8    = 1'b0;
        cc_v_mode = 1'b0;
        cc_c_mode = 1'b0;
        keep_v    = 1'b0;
        lo_sum    = {1'b0, ~regs[src_sel][3:0]} + 5'h01;
        b_sum     = {1'b0, ~regs[src_sel]} + 9'h001;
        w_sum     = {1'b0, ~src_w} + 17'h00001;
        unique case (opc)
            lsa_pkg::OP_OR_BYTE: begin
                res = {8'h00, regs[src_sel] | regs[dst_sel]};
                v_new = 1'b0;
            end
            lsa_pkg::OP_OR_WORD: begin
                res = src_w | dst_w;
                is_word = 1'b1;
            end
            lsa_pkg::OP_XOR_BYTE: begin
                res = {8'h00, regs[src_sel] ^ regs[dst_sel]};
            end
            lsa_pkg::OP_XOR_WORD: begin
                res = src_w ^ dst_w;
                is_word = 1'b1;
            end
            lsa_pkg::OP_INV_BYTE: begin
                res = {8'h00, ~regs[src_sel]};
                keep_v = 1'b1;
                cc_c_mode = 1'b1;
                c_new = 1'b0;
            end
            lsa_pkg::OP_INV_WORD: begin
                res = ~src_w;
                keep_v = 1'b1;
                is_word = 1'b1;
                cc_c_mode = 1'b1;
                c_new = 1'b0;
            end
            lsa_pkg::OP_NEG_BYTE: begin
                res = {8'h00, b_sum[7:0]};
                h_new = lo_sum[4];
                c_new = b_sum[8];
                v_new = (regs[src_sel] == 8'h80);
                upd_h = 1'b1;
                upd_c8 = 1'b1;
                cc_v_mode = 1'b1;
                cc_c_mode = 1'b1;
            end
            lsa_pkg::OP_NEG_WORD: begin
                res = w_sum[15:0];
                is_word = 1'b1;
                c_new = w_sum[16];
                upd_c8 = 1'b1;
            end
            lsa_pkg::OP_SHL_BYTE, lsa_pkg::OP_SHLC_BYTE: begin
                res = {8'h00, regs[src_sel][6:0], (opc == lsa_pkg::OP_SHLC_BYTE) & cc_c};
                c_new = regs[src_sel][7];
                h_new = regs[src_sel][3];
                v_new = regs[src_sel][7] ^ regs[src_sel][6];
                upd_h = 1'b1;
                upd_c8 = 1'b1;
                cc_v_mode = 1'b1;
                cc_c_mode = 1'b1;
            end
            lsa_pkg::OP_SHL_WORD, lsa_pkg::OP_SHLC_WORD: begin
                res = {src_w[14:0], (opc == lsa_pkg::OP_SHLC_WORD) & cc_c};
                is_word = 1'b1;
                c_new = src_w[15];
                h_new = src_w[3];
                v_new = src_w[15] ^ src_w[14];
                upd_h = 1'b1;
                upd_c8 = 1'b1;
                cc_v_mode = 1'b1;
                cc_c_mode = 1'b1;
            end
            lsa_pkg::OP_SHR_BYTE, lsa_pkg::OP_SHRC_BYTE: begin
                res = {8'h00, (opc == lsa_pkg::OP_SHRC_BYTE) & cc_c, regs[src_sel][7:1]};
                c_new = regs[src_sel][0];
                keep_v = 1'b1;
                upd_c8 = 1'b1;
                cc_c_mode = 1'b1;
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // Register file and readback; an execute write to the same register wins over a side-load
    always_comb begin
        for (int i = 0; i < lsa_pkg::NREG; i++) begin
            next_regs[i] = regs[i];
        end
        if (rf_we_i) begin
            next_regs[rf_waddr_i] = rf_wdata_i;
        end
        if (do_wr) begin
            next_regs[dst_sel] = res[7:0];
            if (is_word) begin
                next_regs[dst_hi_sel] = res[15:8];
            end
        end
        next_rf_rdata = (rf_we_i && rf_waddr_i == rf_raddr_i) ? rf_wdata_i : regs[rf_raddr_i];
        if (do_wr && (rf_raddr_i == dst_sel)) begin
            next_rf_rdata = res[7:0];
        end else if (do_wr && is_word && (rf_raddr_i == dst_hi_sel)) begin
            next_rf_rdata = res[15:8];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < lsa_pkg::NREG; i++) begin
                regs[i] <= lsa_pkg::REG_RST;
            end
            rf_rdata <= lsa_pkg::REG_RST;
        end else begin
            for (int i = 0; i < lsa_pkg::NREG; i++) begin
                regs[i] <= next_regs[i];
            end
            rf_rdata <= next_rf_rdata;
        end
    end

    // Negative and zero status follow every implemented operation, carries only under upd_h and upd_c8, whatever the flag-form bit says
    always_comb begin
        next_negative_status   = negative_status;
        next_zero_status       = zero_status;
        next_half_carry_status = half_carry_status;
        next_byte_carry_status = byte_carry_status;
        if (do_wr) begin
            next_negative_status = is_word ? res[15] : res[7];
            next_zero_status     = is_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
            if (upd_h) begin
                next_half_carry_status = h_new;
            end
            if (upd_c8) begin
                next_byte_carry_status = c_new;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            negative_status   <= lsa_pkg::FLAG_RST;
            zero_status       <= lsa_pkg::FLAG_RST;
            half_carry_status <= lsa_pkg::FLAG_RST;
            byte_carry_status <= lsa_pkg::FLAG_RST;
        end else begin
            negative_status   <= next_negative_status;
            zero_status       <= next_zero_status;
            half_carry_status <= next_half_carry_status;
            byte_carry_status <= next_byte_carry_status;
        end
    end

    // Condition codes move only in the flag form; the illegal flag is a one-cycle report
    always_comb begin
        next_cc_n    = cc_n;
        next_cc_z    = cc_z;
        next_cc_v    = cc_v;
        next_cc_c    = cc_c;
        next_illegal = exec_i & ~wr_en;
        if (do_wr && ccu) begin
            next_cc_n = next_negative_status;
            next_cc_z = next_zero_status;
            if (cc_v_mode) begin
                next_cc_v = v_new;
            end else if (!keep_v) begin
                next_cc_v = 1'b0;
            end
            if (cc_c_mode) begin
                next_cc_c = c_new;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cc_n    <= lsa_pkg::FLAG_RST;
            cc_z    <= lsa_pkg::FLAG_RST;
            cc_v    <= lsa_pkg::FLAG_RST;
            cc_c    <= lsa_pkg::FLAG_RST;
            illegal <= lsa_pkg::FLAG_RST;
        end else begin
            cc_n    <= next_cc_n;
            cc_z    <= next_cc_z;
            cc_v    <= next_cc_v;
            cc_c    <= next_cc_c;
            illegal <= next_illegal;
        end
    end

    assign rf_rdata_o          = rf_rdata;
    assign negative_status_o   = negative_status;
    assign zero_status_o       = zero_status;
    assign half_carry_status_o = half_carry_status;
    assign byte_carry_status_o = byte_carry_status;
    assign cc_n_o              = cc_n;
    assign cc_z_o              = cc_z;
    assign cc_v_o              = cc_v;
    assign cc_c_o              = cc_c;
    assign illegal_o           = illegal;
endmodule // lsa_alu

// file: bench/lsa_seq_model.sv
// Sequencer model that issues microinstructions to the ALU slice
`timescale 1ns/100ps
module lsa_seq_model (
    input  wire logic        sys_clk_i,
    output logic             exec_o,
    output logic [15:0]      instr_o
);
    initial begin
        exec_o  = 1'b0;
        instr_o = 16'h0000;
    end
    // One-cycle execute pulse; the word is scrambled once it is no longer sampled
    task automatic issue(input logic [15:0] ins);
        @(posedge sys_clk_i);
        exec_o  <= 1'b1;
        instr_o <= ins;
        @(posedge sys_clk_i);
        exec_o  <= 1'b0;
        instr_o <= ~ins;
    endtask
endmodule // lsa_seq_model

// file: bench/lsa_alu_checker.sv
// Port assertions for the logic and shift ALU slice
`timescale 1ns/100ps
module lsa_alu_checker (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        exec_i,
    input wire logic [15:0] instr_i,
    input wire logic        rf_we_i,
    input wire logic [3:0]  rf_waddr_i,
    input wire logic [7:0]  rf_wdata_i,
    input wire logic [3:0]  rf_raddr_i,
    input wire logic [7:0]  rf_rdata_o,
    input wire logic        negative_status_o,
    input wire logic        zero_status_o,
    input wire logic        half_carry_status_o,
    input wire logic        byte_carry_status_o,
    input wire logic        cc_n_o,
    input wire logic        cc_z_o,
    input wire logic        cc_v_o,
    input wire logic        cc_c_o,
    input wire logic        illegal_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [3:0] st  = {negative_status_o, zero_status_o, half_carry_status_o, byte_carry_status_o};
    wire logic [3:0] cc  = {cc_n_o, cc_z_o, cc_v_o, cc_c_o};
    wire logic [6:0] opc = instr_i[lsa_pkg::OPC_HI:lsa_pkg::OPC_LO];
    wire logic       ccu = instr_i[lsa_pkg::CCU_BIT];
    wire logic       shr = exec_i && (opc inside {lsa_pkg::OP_SHR_BYTE, lsa_pkg::OP_SHRC_BYTE});
    wire logic       orx = exec_i && (opc inside {lsa_pkg::OP_OR_BYTE, lsa_pkg::OP_OR_WORD,
                                                  lsa_pkg::OP_XOR_BYTE, lsa_pkg::OP_XOR_WORD});
    wire logic       inv = exec_i && (opc inside {lsa_pkg::OP_INV_BYTE, lsa_pkg::OP_INV_WORD});
    ill_pulse_a: assert property (illegal_o |=> !illegal_o)
        else $error("illegal flag held too long");
    ill_cause_a: assert property (illegal_o |-> $past(exec_i))
        else $error("illegal flag without execute");
    ill_quiet_a: assert property (illegal_o |-> $stable({st, cc}))
        else $error("flags moved on illegal opcode");
    idle_hold_a: assert property (!exec_i |=> $stable({st, cc}))
        else $error("flags moved without execute");
    orx_carry_a: assert property (orx |=> $stable(st[1:0]))
        else $error("or or xor changed carry status");
    orx_cc_a: assert property (orx && ccu |=> !cc_v_o && $stable(cc_c_o))
        else $error("or or xor flag form wrong on overflow or carry");
    inv_cc_a: assert property (inv && ccu |=> !cc_c_o && $stable(cc_v_o))
        else $error("invert flag form wrong on overflow or carry");
    plain_cc_a: assert property (exec_i && !ccu |=> $stable(cc))
        else $error("plain form changed condition codes");
    negw_hc_a: assert property (exec_i && opc == lsa_pkg::OP_NEG_WORD |=> $stable(half_carry_status_o))
        else $error("negate word changed half carry");
    shl_cc_a: assert property (exec_i && ccu && opc == lsa_pkg::OP_SHL_BYTE
                               |=> cc_c_o == byte_carry_status_o && cc_n_o == negative_status_o
                                   && cc_z_o == zero_status_o)
        else $error("shift left flag form differs from status bits");
    shr_cc_a: assert property (shr && ccu |=> $stable(cc_v_o) && cc_c_o == byte_carry_status_o)
        else $error("shift right flag form wrong on overflow or carry");
endmodule // lsa_alu_checker
bind lsa_alu lsa_alu_checker u_chk (.*);

// file: bench/test_lsa_alu.sv
// Self-checking testbench for the logic and shift ALU slice
`timescale 1ns/100ps
module test_lsa_alu;
    logic        sys_clk_i  = 1'b0;
    logic        rst_i      = 1'b1;
    logic        rf_we_i    = 1'b0;
    logic [3:0]  rf_waddr_i = 4'h0;
    logic [7:0]  rf_wdata_i = 8'h00;
    logic [3:0]  rf_raddr_i = 4'h0;
    wire logic        exec_i;
    wire logic [15:0] instr_i;
    wire logic [7:0]  rf_rdata_o;
    wire logic [7:0]  fl;
    wire logic        illegal_o;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    lsa_seq_model u_seq (.sys_clk_i(sys_clk_i), .exec_o(exec_i), .instr_o(instr_i));
    lsa_alu uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .exec_i(exec_i), .instr_i(instr_i), .rf_we_i(rf_we_i),
        .rf_waddr_i(rf_waddr_i), .rf_wdata_i(rf_wdata_i), .rf_raddr_i(rf_raddr_i), .rf_rdata_o(rf_rdata_o),
        .negative_status_o(fl[7]), .zero_status_o(fl[6]), .half_carry_status_o(fl[5]),
        .byte_carry_status_o(fl[4]), .cc_n_o(fl[3]), .cc_z_o(fl[2]), .cc_v_o(fl[1]), .cc_c_o(fl[0]),
        .illegal_o(illegal_o));
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        rf_we_i    <= 1'b1;
        rf_waddr_i <= a;
        rf_wdata_i <= d;
        @(posedge sys_clk_i);
        rf_we_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rf_raddr_i <= a;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk("register", e, rf_rdata_o);
    endtask
    // Flags are {N, Z, half carry, byte carry, cc n, cc z, cc v, cc c}
    task automatic ex(input logic [15:0] ins, input logic [7:0] e);
        u_seq.issue(ins);
        @(negedge sys_clk_i);
        chk("flags", e, fl);
    endtask
    task automatic t_or;
        wr(4'h4, 8'h81);
        wr(4'h6, 8'h7e);
        ex({lsa_pkg::OP_OR_BYTE, 1'b1, 4'h6, 4'h4}, 8'h88);
        rd(4'h4, 8'hff);
        rd(4'h6, 8'h7e);
        wr(4'h2, 8'haa);
        wr(4'h3, 8'haa);
        wr(4'h8, 8'h55);
        wr(4'h9, 8'h55);
        ex({lsa_pkg::OP_OR_WORD, 1'b0, 4'h8, 4'h2}, 8'h88);
        rd(4'h3, 8'hff);
        rd(4'h9, 8'h55);
        $display("or test done");
    endtask
    task automatic t_xor;
        wr(4'h5, 8'h81);
        wr(4'h7, 8'h81);
        ex({lsa_pkg::OP_XOR_BYTE, 1'b1, 4'h7, 4'h5}, 8'h44);
        rd(4'h5, 8'h00);
        ex({lsa_pkg::OP_XOR_WORD, 1'b0, 4'h8, 4'h2}, 8'h84);
        rd(4'h2, 8'haa);
        rd(4'h3, 8'haa);
        $display("xor test done");
    endtask
    task automatic t_inv;
        wr(4'ha, 8'h01);
        ex({lsa_pkg::OP_INV_BYTE, 1'b1, 4'ha, 4'hb}, 8'h88);
        rd(4'hb, 8'hfe);
        wr(4'hd, 8'h80);
        ex({lsa_pkg::OP_INV_WORD, 1'b0, 4'hd, 4'h0}, 8'h08);
        rd(4'h0, 8'h7f);
        rd(4'h1, 8'h00);
        $display("invert test done");
    endtask
    task automatic t_neg;
        wr(4'hc, 8'h00);
        ex({lsa_pkg::OP_NEG_BYTE, 1'b1, 4'hc, 4'he}, 8'h75);
        rd(4'he, 8'h00);
        wr(4'hc, 8'h01);
        wr(4'hd, 8'h00);
        ex({lsa_pkg::OP_NEG_WORD, 1'b0, 4'hc, 4'he}, 8'ha5);
        rd(4'hf, 8'hff);
        $display("negate test done");
    endtask
    task automatic t_shl;
        wr(4'hf, 8'h88);
        ex({lsa_pkg::OP_SHL_BYTE, 1'b1, 4'hf, 4'h3}, 8'h33);
        rd(4'h3, 8'h10);
        rd(4'hf, 8'h88);
        u_seq.issue({7'h00, 1'b1, 4'h0, 4'h0});
        @(negedge sys_clk_i);
        chk("illegal", 8'h01, {7'h00, illegal_o});
        chk("flags", 8'h33, fl);
        $display("shift and illegal test done");
    endtask
    task automatic t_carry;
        wr(4'h4, 8'h41);
        ex({lsa_pkg::OP_SHLC_BYTE, 1'b1, 4'h4, 4'h5}, 8'h8a);
        rd(4'h5, 8'h83);
        ex({lsa_pkg::OP_SHRC_BYTE, 1'b1, 4'h5, 4'h6}, 8'h13);
        rd(4'h6, 8'h41);
        ex({lsa_pkg::OP_SHRC_BYTE, 1'b0, 4'h4, 4'h7}, 8'h93);
        rd(4'h7, 8'ha0);
        ex({lsa_pkg::OP_SHR_BYTE, 1'b1, 4'h7, 4'h8}, 8'h02);
        rd(4'h8, 8'h50);
        ex({lsa_pkg::OP_SHL_WORD, 1'b1, 4'h4, 4'ha}, 8'h13);
        rd(4'hb, 8'h06);
        ex({lsa_pkg::OP_SHLC_WORD, 1'b0, 4'ha, 4'hc}, 8'h03);
        rd(4'hc, 8'h05);
        rd(4'hd, 8'h0d);
        $display("carry shift test done");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_or();
        t_xor();
        t_inv();
        t_neg();
        t_shl();
        t_carry();
        close_out();
    end
endmodule // test_lsa_alu
